// ### hdl/ir_mod_pkg.sv
// Constants and state type for the carrier modulator
package ir_mod_pkg;

  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [7:0] OFS_MOD_CTRL = 8'h02;
  localparam logic [7:0] OFS_OVF_CTRL = 8'h03;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PORT_A = 8'h1B;

  // Field positions
  localparam int unsigned ON_TIME_LSB = 3;
  localparam int unsigned LED_BIT = 2;

  // Reset values
  localparam logic [7:0] MOD_CTRL_RST = 8'h00;
  localparam logic [3:0] PORT_A_RST = 4'h4;
  localparam logic [1:0] OVF_CTRL_RST = 2'h0;

  // Duty configurations
  localparam logic [2:0] CONF_OFF = 3'h0;
  localparam logic [2:0] CONF_RSVD = 3'h6;
  localparam logic [2:0] CONF_HF = 3'h7;

  // Overflow output modes
  localparam logic [1:0] OOM_NONE = 2'h0;
  localparam logic [1:0] OOM_TOGGLE = 2'h1;
  localparam logic [1:0] OOM_CLEAR = 2'h2;
  localparam logic [1:0] OOM_SET = 2'h3;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_ON = 3'b010,
    PH_OFF = 3'b100
  } phase_e;

endpackage

// ### hdl/ir_carrier_modulator.sv
// Infrared carrier modulator driving the high-current LED pin
// Notes on behaviour
// - Pulse low for one to three units of on-time count plus one
// - Duty config sets on and off units
// - Config zero: pin follows port bit
// - Config 111 gates pin with clock
// - Port bit one forces pin high
// - One timer tick per modulation period
// - Tick continues while modulation stopped
// - Timer overflow may set or clear pin
// - Pin goes low only at cycle start in configs 1 to 5
// - Control rewrites apply at next cycle
// - On-time count spans zero to 31
// - Pin always driven, no direction control
// - Pin and port outputs delayed one extra cycle
`timescale 1ns/100ps
`default_nettype none

module ir_carrier_modulator (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // Register port
  input wire logic [ir_mod_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [ir_mod_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [ir_mod_pkg::DATA_W-1:0] RDATA_O,
  // Burst timer link
  input wire logic TMR_OVF_I,
  output logic MOD_TICK_O,
  // LED pad
  output logic LED_LEVEL_O,
  output logic LED_CLK_GATE_O,
  output logic [3:0] PORT_A_O
);
  import ir_mod_pkg::*;

  typedef struct packed {
    logic [7:0] mod_ctrl;
    logic [3:0] port_a;
    logic [1:0] oom;
    logic [4:0] cur_on_time;
    logic [2:0] cur_conf;
    phase_e ph;
    logic [6:0] cnt;
    logic running;
    logic lvl1;
    logic gate1;
    logic [3:0] port1;
    logic lvl_out;
    logic gate_out;
    logic [3:0] port_out;
    logic tick;
    logic [7:0] rdata;
  } state_s;

  localparam state_s S_RESET = '{
    mod_ctrl: MOD_CTRL_RST,
    port_a: PORT_A_RST,
    oom: OVF_CTRL_RST,
    cur_on_time: 5'h00,
    cur_conf: CONF_OFF,
    ph: PH_IDLE,
    cnt: 7'h00,
    running: 1'b0,
    lvl1: 1'b1,
    gate1: 1'b0,
    port1: PORT_A_RST,
    lvl_out: 1'b1,
    gate_out: 1'b0,
    port_out: PORT_A_RST,
    tick: 1'b0,
    rdata: 8'h00
  };

  state_s s_reg;
  state_s s_next;

  // Phase length in clocks for a config, unit and phase
  function automatic logic [6:0] ph_len(input logic [2:0] conf,
                                        input logic [4:0] on_time,
                                        input logic is_on);
    logic [6:0] u;
    u = {2'h0, on_time} + 7'h01;
    ph_len = u;
    if (is_on && conf == 3'h4) begin
      ph_len = 7'(u << 1);
    end
    if (is_on && conf == 3'h5) begin
      ph_len = 7'(u * 7'h03);
    end
    if (!is_on && conf == 3'h2) begin
      ph_len = 7'(u << 1);
    end
    if (!is_on && conf == 3'h3) begin
      ph_len = 7'(u * 7'h03);
    end
  endfunction

  function automatic logic counted(input logic [2:0] conf);
    counted = conf != CONF_OFF && conf != CONF_RSVD && conf != CONF_HF;
  endfunction

  logic led_bit;
  logic cyc_start;
  logic [2:0] new_conf;
  logic [4:0] new_on_time;
  logic [6:0] on_len_now;

  assign led_bit = s_reg.port_a[LED_BIT];
  assign new_conf = s_reg.mod_ctrl[2:0];
  assign new_on_time = s_reg.mod_ctrl[7:ON_TIME_LSB];
  assign on_len_now = ph_len(s_reg.cur_conf, s_reg.cur_on_time, 1'b1);
  assign cyc_start = s_reg.ph == PH_IDLE ||
                     (s_reg.ph == PH_OFF && s_reg.cnt == 7'h01);

  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    s_next.rdata = 8'h00;

    // Register writes
    if (WR_I) begin
      unique case (ADDR_I)
        OFS_MOD_CTRL: s_next.mod_ctrl = WDATA_I;
        OFS_OVF_CTRL: s_next.oom = WDATA_I[1:0];
        OFS_PORT_A: s_next.port_a = WDATA_I[3:0];
        default: ;
      endcase
    end

    // Overflow applied after a same-cycle write, so it wins
    if (TMR_OVF_I) begin
      unique case (s_reg.oom)
        OOM_NONE: ;
        OOM_TOGGLE: s_next.port_a[LED_BIT] = ~s_next.port_a[LED_BIT];
        OOM_CLEAR: s_next.port_a[LED_BIT] = 1'b0;
        OOM_SET: s_next.port_a[LED_BIT] = 1'b1;
      endcase
    end

    // Reads answer one cycle later; unmapped reads give zero
    if (RD_I) begin
      unique case (ADDR_I)
        OFS_MOD_CTRL: s_next.rdata = s_reg.mod_ctrl;
        OFS_OVF_CTRL: s_next.rdata = {6'h00, s_reg.oom};
        OFS_PORT_A: s_next.rdata = {4'h0, s_reg.port_a};
        OFS_STATUS: s_next.rdata = {5'h00, s_reg.ph == PH_ON,
                                    s_reg.tick, s_reg.running};
        default: s_next.rdata = 8'h00;
      endcase
    end

    // Period engine runs regardless of the port bit
    s_next.tick = (s_reg.ph == PH_OFF && s_reg.cnt == 7'h01) ||
                  (s_reg.ph == PH_IDLE && s_reg.cur_conf == CONF_HF);
    unique case (s_reg.ph)
      PH_ON: begin
        if (s_reg.cnt == 7'h01) begin
          s_next.ph = PH_OFF;
          s_next.cnt = ph_len(s_reg.cur_conf, s_reg.cur_on_time, 1'b0);
        end else begin
          s_next.cnt = s_reg.cnt - 7'h01;
        end
      end
      PH_OFF: begin
        if (s_reg.cnt != 7'h01) begin
          s_next.cnt = s_reg.cnt - 7'h01;
        end
      end
      PH_IDLE: ;
    endcase

    // New settings load only at a cycle boundary
    if (cyc_start) begin
      s_next.cur_conf = new_conf;
      s_next.cur_on_time = new_on_time;
      s_next.running = !led_bit && new_conf != CONF_OFF &&
                       new_conf != CONF_RSVD;
      if (counted(new_conf)) begin
        s_next.ph = PH_ON;
        s_next.cnt = ph_len(new_conf, new_on_time, 1'b1);
      end else begin
        s_next.ph = PH_IDLE;
        s_next.cnt = 7'h00;
      end
    end

    // Stopping is immediate, restarting waits for a boundary
    if (led_bit) begin
      s_next.running = 1'b0;
    end

    // Pin level from current state
    s_next.gate1 = 1'b0;
    if (led_bit) begin
      s_next.lvl1 = 1'b1;
    end else if (s_reg.cur_conf == CONF_OFF ||
                 s_reg.cur_conf == CONF_RSVD) begin
      s_next.lvl1 = 1'b0;
    end else if (s_reg.cur_conf == CONF_HF) begin
      s_next.lvl1 = 1'b1;
      s_next.gate1 = s_reg.running;
    end else begin
      s_next.lvl1 = !(s_reg.running && s_reg.ph == PH_ON);
    end
    s_next.port1 = s_reg.port_a;

    // Extra stage delays pin, gate and port outputs alike by one cycle
    s_next.lvl_out = s_reg.lvl1;
    s_next.gate_out = s_reg.gate1;
    s_next.port_out = s_reg.port1;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      s_reg <= S_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Pad is the clock when the gate is high, else the level
  assign LED_LEVEL_O = s_reg.lvl_out;
  assign LED_CLK_GATE_O = s_reg.gate_out;
  assign PORT_A_O = s_reg.port_out;
  assign MOD_TICK_O = s_reg.tick;
  assign RDATA_O = s_reg.rdata;

  // Helper run-length counters seen only by assertions
  logic [7:0] low_run;
  logic [7:0] high_run;
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      low_run <= 8'h00;
      high_run <= 8'h00;
    end else begin
      low_run <= s_reg.lvl1 ? 8'h00 : low_run + 8'h01;
      high_run <= s_reg.lvl1 ? high_run + 8'h01 : 8'h00;
    end
  end

  sequence s_ctrl_tick0;
    s_reg.tick && s_reg.cur_conf == 3'h1 && s_reg.cur_on_time == 5'h00;
  endsequence

  sequence s_port_rise;
    WR_I && ADDR_I == OFS_PORT_A && WDATA_I[2] && !TMR_OVF_I;
  endsequence

  property p_on_len;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    $rose(s_reg.lvl1) && !led_bit && s_reg.cur_conf inside {3'h1, 3'h2}
    |-> low_run == {3'h0, s_reg.cur_on_time} + 8'h01;
  endproperty
  a_on_len: assert property (p_on_len) else $error("on time wrong");

  property p_off_len;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    $fell(s_reg.lvl1) && $past(s_reg.running, 2) && s_reg.cur_conf == 3'h2
    |-> high_run == 8'(({3'h0, s_reg.cur_on_time} + 8'h01) << 1);
  endproperty
  a_off_len: assert property (p_off_len) else $error("off time wrong");

  property p_unmod;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    !led_bit && s_reg.cur_conf == CONF_OFF |=> !s_reg.lvl1 ##1 !LED_LEVEL_O;
  endproperty
  a_unmod: assert property (p_unmod) else $error("not unmodulated");

  property p_hf;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    s_reg.cur_conf == CONF_HF && s_reg.running && !led_bit
    |-> ##2 LED_CLK_GATE_O;
  endproperty
  a_hf: assert property (p_hf) else $error("clock gate missing");

  property p_rsvd;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    !led_bit && s_reg.cur_conf == CONF_RSVD |=> !s_reg.lvl1 && !s_reg.gate1;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved not steady");

  property p_tick_period;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    s_ctrl_tick0 and ##0 s_reg.mod_ctrl == 8'h01 |-> ##2 s_reg.tick;
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("tick period wrong");

  property p_start_edge;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    $fell(s_reg.lvl1) && counted($past(s_reg.cur_conf))
    |-> $past(s_reg.cnt) == $past(on_len_now);
  endproperty
  a_start_edge: assert property (p_start_edge)
    else $error("low mid cycle");

  property p_hold_cfg;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    !cyc_start |=> $stable(s_reg.cur_conf) && $stable(s_reg.cur_on_time);
  endproperty
  a_hold_cfg: assert property (p_hold_cfg) else $error("config early");

  property p_delay;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    s_port_rise |-> ##3 LED_LEVEL_O;
  endproperty
  a_delay: assert property (p_delay) else $error("port delay wrong");

  property p_ovf_clr;
    @(posedge CLK_SYS_I) disable iff (RST_I)
    TMR_OVF_I && s_reg.oom == OOM_CLEAR |=> !led_bit;
  endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("overflow clear");

endmodule

`default_nettype wire

// ### verification/led_emitter.sv
// Behavioural LED emitter that measures low and high run lengths
`timescale 1ns/100ps
`default_nettype none

module led_emitter (
  // Clock
  input wire logic clk_i,
  // Pad drive from the modulator
  input wire logic level_i,
  input wire logic gate_i,
  // Observations
  output logic pad_o,
  output logic [7:0] low_len_o,
  output logic [7:0] high_len_o
);
  logic [7:0] run = 8'h00;
  logic prev = 1'b1;

  // Pad follows the clock while gated
  assign pad_o = gate_i ? clk_i : level_i;

  // Run length counted in whole clocks of one level
  always @(posedge clk_i) begin
    if (level_i != prev) begin
      if (prev) begin
        high_len_o <= run;
      end else begin
        low_len_o <= run;
      end
      run <= 8'h01;
    end else begin
      run <= run + 8'h01;
    end
    prev <= level_i;
  end
endmodule

`default_nettype wire

// ### verification/ir_carrier_modulator_tb.sv
// Self-checking bench for the infrared carrier modulator
`timescale 1ns/100ps
`default_nettype none

module ir_carrier_modulator_tb;
  import ir_mod_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ovf = 1'b0;
  logic [7:0] rdata;
  logic tick;
  logic led;
  logic gate;
  logic [3:0] port_a;
  logic pad;
  logic [7:0] low_len;
  logic [7:0] high_len;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  ir_carrier_modulator u_dut (
    .CLK_SYS_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TMR_OVF_I(ovf),
    .MOD_TICK_O(tick), .LED_LEVEL_O(led), .LED_CLK_GATE_O(gate),
    .PORT_A_O(port_a)
  );

  led_emitter u_led (
    .clk_i(clk), .level_i(led), .gate_i(gate), .pad_o(pad),
    .low_len_o(low_len), .high_len_o(high_len)
  );

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A hung wait must not stall the run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  // Strobe released one edge before the next task may raise it
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("read", rdata, exp);
  endtask

  task automatic pulse();
    @(posedge clk);
    ovf <= 1'b1;
    @(posedge clk);
    ovf <= 1'b0;
  endtask

  task automatic wait_led(input logic v);
    int n;
    n = 0;
    while (led !== v && n < 300) begin
      step();
      n++;
    end
    chk("led wait", led, v);
  endtask

  task automatic tick_gap(output logic [7:0] g);
    int n;
    n = 0;
    while (tick !== 1'b1 && n < 300) begin
      step();
      n++;
    end
    g = 8'h00;
    do begin
      step();
      g++;
    end while (tick !== 1'b1 && g < 8'hFF);
  endtask

  task automatic t_reset();
    rd_chk(OFS_MOD_CTRL, MOD_CTRL_RST);
    rd_chk(OFS_PORT_A, {4'h0, PORT_A_RST});
    rd_chk(8'h10, 8'h00);
    chk("reset led", led, 1'b1);
    wr_reg(OFS_MOD_CTRL, 8'hA5);
    rd_chk(OFS_MOD_CTRL, 8'hA5);
    $display("test reset done");
  endtask

  task automatic t_shapes();
    logic [4:0] ot [5] = '{5'd0, 5'd1, 5'd31, 5'd2, 5'd0};
    int on_m [5] = '{1, 1, 1, 2, 3};
    int off_m [5] = '{1, 2, 3, 1, 1};
    int u;
    logic [7:0] g;
    for (int i = 0; i < 5; i++) begin
      u = int'(ot[i]) + 1;
      wr_reg(OFS_MOD_CTRL, {ot[i], 3'(i + 1)});
      wr_reg(OFS_PORT_A, 8'h00);
      wait_led(1'b0);
      wait_led(1'b1);
      step();
      chk("on time", low_len, 8'(on_m[i] * u));
      wait_led(1'b0);
      step();
      chk("off time", high_len, 8'(off_m[i] * u));
      tick_gap(g);
      chk("period", g, 8'((on_m[i] + off_m[i]) * u));
      wr_reg(OFS_PORT_A, 8'h04);
      repeat (3) step();
      chk("stopped", led, 1'b1);
      tick_gap(g);
      chk("idle period", g, 8'((on_m[i] + off_m[i]) * u));
    end
    $display("test shapes done");
  endtask

  task automatic t_plain();
    logic [2:0] cf [2] = '{CONF_OFF, CONF_RSVD};
    int nt;
    for (int i = 0; i < 2; i++) begin
      wr_reg(OFS_MOD_CTRL, {5'h1F, cf[i]});
      wr_reg(OFS_PORT_A, 8'h00);
      repeat (8) step();
      nt = 0;
      repeat (40) begin
        step();
        nt += int'(tick === 1'b1);
      end
      chk("plain level", led, 1'b0);
      chk("no tick", 8'(nt), 8'h00);
      wr_reg(OFS_PORT_A, 8'h04);
      step();
      chk("pin delay", led, 1'b0);
      step();
      chk("pin delay", led, 1'b1);
      chk("port delay", {4'h0, port_a}, 8'h04);
    end
    $display("test plain done");
  endtask

  task automatic t_hf();
    logic [7:0] g;
    wr_reg(OFS_MOD_CTRL, {5'h00, CONF_HF});
    wr_reg(OFS_PORT_A, 8'h00);
    repeat (4) step();
    chk("gate", gate, 1'b1);
    rd_chk(OFS_STATUS, 8'h03);
    @(negedge clk);
    #1;
    chk("pad low", pad, 1'b0);
    @(posedge clk);
    #1;
    chk("pad high", pad, 1'b1);
    tick_gap(g);
    chk("hf tick", g, 8'h01);
    wr_reg(OFS_PORT_A, 8'h04);
    repeat (3) step();
    chk("gate off", gate, 1'b0);
    chk("hf stop", led, 1'b1);
    $display("test high frequency done");
  endtask

  task automatic t_ovf();
    wr_reg(OFS_MOD_CTRL, 8'h01);
    wr_reg(OFS_OVF_CTRL, {6'h00, OOM_CLEAR});
    pulse();
    wait_led(1'b0);
    rd_chk(OFS_PORT_A, 8'h00);
    wr_reg(OFS_OVF_CTRL, {6'h00, OOM_SET});
    pulse();
    repeat (3) step();
    chk("ovf stop", led, 1'b1);
    rd_chk(OFS_PORT_A, 8'h04);
    rd_chk(OFS_OVF_CTRL, {6'h00, OOM_SET});
    wr_reg(OFS_OVF_CTRL, {6'h00, OOM_TOGGLE});
    pulse();
    rd_chk(OFS_PORT_A, 8'h00);
    pulse();
    rd_chk(OFS_PORT_A, 8'h04);
    wr_reg(OFS_OVF_CTRL, {6'h00, OOM_NONE});
    pulse();
    rd_chk(OFS_PORT_A, 8'h04);
    $display("test overflow done");
  endtask

  task automatic t_rewrite();
    wr_reg(OFS_MOD_CTRL, {5'd3, 3'h1});
    wr_reg(OFS_PORT_A, 8'h00);
    wait_led(1'b0);
    wr_reg(OFS_MOD_CTRL, 8'h01);
    wait_led(1'b1);
    step();
    chk("old on", low_len, 8'd4);
    wait_led(1'b0);
    step();
    chk("old off", high_len, 8'd4);
    wait_led(1'b1);
    step();
    chk("new on", low_len, 8'd1);
    wr_reg(OFS_PORT_A, 8'h04);
    $display("test rewrite done");
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_shapes();
    t_plain();
    t_hf();
    t_ovf();
    t_rewrite();
    complete_run();
  end
endmodule

`default_nettype wire
